// ### rtl/fld_defines.vh
`ifndef FLD_DEFINES_VH
`define FLD_DEFINES_VH

// =====================================================================
// register offsets
`define FLD_ADDR_CTRL 12'h104
`define FLD_ADDR_CUT 12'h105
`define FLD_ADDR_FUT_LO 12'h106
`define FLD_ADDR_FUT_HI 12'h107
`define FLD_ADDR_FLT_LO 12'h108
`define FLD_ADDR_FLT_HI 12'h109
`define FLD_ADDR_DWELL_LO 12'h10a
`define FLD_ADDR_DWELL_HI 12'h10b

// =====================================================================
// control register fields
`define FLD_CTRL_EN_BIT 0
`define FLD_CTRL_MODE_LSB 1
`define FLD_CTRL_MODE_MSB 3

// =====================================================================
// reset values
`define FLD_RST_CTRL 8'h00
`define FLD_RST_CUT 3'h7
`define FLD_RST_FINE 13'h0000
`define FLD_RST_DWELL 16'h0001

// =====================================================================
// mode codes
`define FLD_MODE_MAG4 3'h0
`define FLD_MODE_MAG3 3'h1
`define FLD_MODE_MAG2_OR 3'h2
`define FLD_MODE_MAG2_CUT 3'h3
`define FLD_MODE_FLAGS 3'h4
`define FLD_MODE_GAIN 3'h5

// =====================================================================
// latencies in sample clock cycles, the output flop included
`define FLD_LAT_FAST 2
`define FLD_LAT_SUBSET 6
`define FLD_LAT_OVR 12

`endif

// ### rtl/fld_dly.v
`timescale 1ns/1ns
`default_nettype none

// =====================================================================
// fixed-length delay line, one flop per stage
module fld_dly #(
  parameter WIDTH = 1,
  parameter DEPTH = 1
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // data
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  // stage storage, index 0 is the newest
  reg [WIDTH-1:0] stage_q [0:DEPTH-1];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_stage
      // each stage takes the one before it
      always @(posedge sys_clk)
      begin
        if (sys_rst)
          stage_q[i] <= {WIDTH{1'b0}};
        else if (i == 0)
          stage_q[i] <= din;
        else
          stage_q[i] <= stage_q[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate

  assign dout = stage_q[DEPTH-1];

endmodule

`default_nettype wire

// ### rtl/fld_top.v
`timescale 1ns/1ns
`default_nettype none
`include "fld_defines.vh"

module fld_top (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // register access port, one register set per channel
  input wire reg_chan,
  input wire [11:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // converter datapath, channel 0 in the low slice
  input wire [7:0] coarse_mag,
  input wire [19:0] sample_data,
  input wire [1:0] ovr_in,
  // level flag pins, channel 0 in the low nibble
  output reg [7:0] level_flag_pins
);

  // =====================================================================
  // register storage, indexed by channel
  reg [7:0] ctrl_q [0:1]; // enable and mode
  reg [2:0] cut_q [0:1]; // coarse-high level
  reg [12:0] fut_q [0:1]; // fine-high level
  reg [12:0] flt_q [0:1]; // fine-low level
  reg [15:0] dwell_q [0:1]; // gain-raise dwell count

  // selected channel view for reads
  wire [7:0] rd_ctrl = ctrl_q[reg_chan];
  wire [2:0] rd_cut = cut_q[reg_chan];
  wire [12:0] rd_fut = fut_q[reg_chan];
  wire [12:0] rd_flt = flt_q[reg_chan];
  wire [15:0] rd_dwell = dwell_q[reg_chan];

  // read mux, unmapped offsets return zero
  reg [7:0] rd_d;
  always @*
  begin
    rd_d = 8'h00;
    if (reg_addr == `FLD_ADDR_CTRL)
      rd_d = {4'h0, rd_ctrl[3:0]};
    else if (reg_addr == `FLD_ADDR_CUT)
      rd_d = {5'h00, rd_cut};
    else if (reg_addr == `FLD_ADDR_FUT_LO)
      rd_d = rd_fut[7:0];
    else if (reg_addr == `FLD_ADDR_FUT_HI)
      rd_d = {3'h0, rd_fut[12:8]};
    else if (reg_addr == `FLD_ADDR_FLT_LO)
      rd_d = rd_flt[7:0];
    else if (reg_addr == `FLD_ADDR_FLT_HI)
      rd_d = {3'h0, rd_flt[12:8]};
    else if (reg_addr == `FLD_ADDR_DWELL_LO)
      rd_d = rd_dwell[7:0];
    else if (reg_addr == `FLD_ADDR_DWELL_HI)
      rd_d = rd_dwell[15:8];
  end

  // read data registered, updated only on a read strobe
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_d;
  end

  // per-channel next pin values
  wire [7:0] pins_d;

  // pins straight from one flop per channel slice
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      level_flag_pins <= 8'h00;
    else
      level_flag_pins <= pins_d;
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_chan
      // =================================================================
      // register writes for this channel
      wire wr_here = reg_wr && (reg_chan == ch);
      always @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          ctrl_q[ch] <= `FLD_RST_CTRL;
          cut_q[ch] <= `FLD_RST_CUT;
          fut_q[ch] <= `FLD_RST_FINE;
          flt_q[ch] <= `FLD_RST_FINE;
          dwell_q[ch] <= `FLD_RST_DWELL;
        end
        else if (wr_here)
        begin
          if (reg_addr == `FLD_ADDR_CTRL)
            ctrl_q[ch] <= {4'h0, reg_wdata[3:0]};
          else if (reg_addr == `FLD_ADDR_CUT)
            cut_q[ch] <= reg_wdata[2:0];
          else if (reg_addr == `FLD_ADDR_FUT_LO)
            fut_q[ch][7:0] <= reg_wdata;
          else if (reg_addr == `FLD_ADDR_FUT_HI)
            fut_q[ch][12:8] <= reg_wdata[4:0];
          else if (reg_addr == `FLD_ADDR_FLT_LO)
            flt_q[ch][7:0] <= reg_wdata;
          else if (reg_addr == `FLD_ADDR_FLT_HI)
            flt_q[ch][12:8] <= reg_wdata[4:0];
          else if (reg_addr == `FLD_ADDR_DWELL_LO)
            dwell_q[ch][7:0] <= reg_wdata;
          else if (reg_addr == `FLD_ADDR_DWELL_HI)
            dwell_q[ch][15:8] <= reg_wdata;
        end
      end

      // =================================================================
      // coarse magnitude codes from the early stage
      wire [3:0] mag4 = coarse_mag[ch*4 +: 4];
      // top step saturates into the three-bit code
      wire [2:0] mag3 = mag4[3] ? 3'h7 : mag4[2:0];

      // fast path: one stage here plus the pin flop
      reg [3:0] mag4_q;
      // coarse-high compare stage and its stretch stage
      reg cut_s1_q;
      reg cut_s2_q;
      always @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          mag4_q <= 4'h0;
          cut_s1_q <= 1'b0;
          cut_s2_q <= 1'b0;
        end
        else
        begin
          mag4_q <= mag4;
          cut_s1_q <= (mag3 >= cut_q[ch]);
          cut_s2_q <= cut_s1_q;
        end
      end
      // held one extra cycle so it never shows shorter than two
      wire cut_flag = cut_s1_q | cut_s2_q;

      // subset path: five stages plus the pin flop make six
      wire [2:0] mag3_dly;
      fld_dly #(
        .WIDTH(3),
        .DEPTH(`FLD_LAT_SUBSET - 1)
      ) u_mag_dly (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .din(mag3),
        .dout(mag3_dly)
      );
      // two-bit code drops the lsb of the delayed three-bit one
      wire [1:0] mag2_dly = mag3_dly[2:1];

      // overrange runs the full pipeline, eleven stages plus pin flop
      wire ovr_flag;
      fld_dly #(
        .WIDTH(1),
        .DEPTH(`FLD_LAT_OVR - 1)
      ) u_ovr_dly (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .din(ovr_in[ch]),
        .dout(ovr_flag)
      );

      // =================================================================
      // fine compares at the pipeline output, on magnitude only
      wire [9:0] smp = sample_data[ch*10 +: 10];
      wire [9:0] smp_abs = smp[9] ? (~smp + 10'h001) : smp;
      // most negative code gives 512 as an unsigned 10-bit value
      wire [13:0] mag_fine = {smp_abs, 4'h0};
      reg fine_hi_q; // above fine-high level
      reg fine_lo_q; // below fine-low level
      reg gain_up_q; // dwell below fine-low completed
      reg [15:0] dwell_cnt_q; // cycles spent below fine-low
      // a zero dwell is treated as one, the least legal count
      wire [15:0] dwell_eff = (dwell_q[ch] == 16'h0000) ? 16'h0001 : dwell_q[ch];
      wire below_low = (mag_fine < {1'b0, flt_q[ch]});
      always @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          fine_hi_q <= 1'b0;
          fine_lo_q <= 1'b0;
          gain_up_q <= 1'b0;
          dwell_cnt_q <= 16'h0000;
        end
        else
        begin
          fine_hi_q <= (mag_fine > {1'b0, fut_q[ch]});
          fine_lo_q <= below_low;
          // counter saturates rather than wrapping back to zero
          if (!below_low)
            dwell_cnt_q <= 16'h0000;
          else if (dwell_cnt_q != 16'hffff)
            dwell_cnt_q <= dwell_cnt_q + 16'h0001;
          gain_up_q <= below_low && (dwell_cnt_q >= dwell_eff - 16'h0001);
        end
      end

      // =================================================================
      // pin selection by mode, all zero while disabled
      reg [3:0] sel;
      always @*
      begin
        sel = 4'h0;
        if (ctrl_q[ch][`FLD_CTRL_EN_BIT])
        begin
          case (ctrl_q[ch][`FLD_CTRL_MODE_MSB:`FLD_CTRL_MODE_LSB])
            `FLD_MODE_MAG4: sel = mag4_q;
            `FLD_MODE_MAG3: sel = {mag3_dly, ovr_flag};
            `FLD_MODE_MAG2_OR: sel = {mag2_dly, ovr_flag, fine_lo_q};
            `FLD_MODE_MAG2_CUT: sel = {mag2_dly, cut_flag, fine_lo_q};
            `FLD_MODE_FLAGS: sel = {ovr_flag, cut_flag, fine_hi_q, fine_lo_q};
            `FLD_MODE_GAIN: sel = {ovr_flag, fine_hi_q, gain_up_q, cut_flag};
            // codes 110 and 111 are not configurations
            default: sel = 4'h0;
          endcase
        end
      end
      assign pins_d[ch*4 +: 4] = sel;
    end
  endgenerate

endmodule

`default_nettype wire

// ### verification/fld_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// checker on channel 0 pins and the register port
module fld_top_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic reg_chan,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // datapath and pins
  input wire logic [7:0] coarse_mag,
  input wire logic [19:0] sample_data,
  input wire logic [1:0] ovr_in,
  input wire logic [7:0] level_flag_pins
);
  logic [3:0] ctl_q; // shadow of channel 0 control
  logic [3:0] age_q; // saturating count since last control write
  wire [3:0] p = level_flag_pins[3:0];
  wire [2:0] m = ctl_q[3:1];
  wire ok = ctl_q[0] && (age_q == 4'hf); // history fully refilled
  // shadow follows writes; bits above 3 are ignored by the design
  always @(posedge sys_clk)
  begin
    if (sys_rst || (reg_wr && !reg_chan && reg_addr == 12'h104))
      age_q <= 4'h0;
    else if (age_q != 4'hf)
      age_q <= age_q + 4'h1;
    if (sys_rst)
      ctl_q <= 4'h0;
    else if (reg_wr && !reg_chan && reg_addr == 12'h104)
      ctl_q <= reg_wdata[3:0];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence held_two;
    p[2] [*2];
  endsequence
  mag4_lat_a: assert property (ok && m == 3'h0 |-> p == $past(coarse_mag[3:0], 2))
    else $error("four-bit code latency wrong");
  mag3_lat_a: assert property (ok && m == 3'h1 |->
    p[3:1] == ($past(coarse_mag[3], 6) ? 3'h7 : $past(coarse_mag[2:0], 6)))
    else $error("three-bit code wrong");
  ovr_lat_a: assert property (ok && m == 3'h1 |-> p[0] == $past(ovr_in[0], 12))
    else $error("overrange latency wrong");
  mag2_lat_a: assert property (ok && m[2:1] == 2'h1 |->
    p[3:2] == ($past(coarse_mag[3], 6) ? 2'h3 : $past(coarse_mag[2:1], 6)))
    else $error("two-bit code wrong");
  off_zero_a: assert property (age_q > 4'h3 && !ctl_q[0] |-> p == 4'h0)
    else $error("pins active while disabled");
  bad_mode_a: assert property (age_q > 4'h3 && ctl_q[0] && m > 3'h5 |-> p == 4'h0)
    else $error("reserved mode drives pins");
  cut_hold_a: assert property (ok && m == 3'h4 && $rose(p[2]) |-> held_two)
    else $error("coarse-high too short");
  unmap_rd_a: assert property (
    reg_rd && (reg_addr < 12'h104 || reg_addr > 12'h10b)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  ctrl_rd_a: assert property (
    reg_rd && !reg_chan && reg_addr == 12'h104
    |=> reg_rdata == {4'h0, ctl_q}) else $error("control readback wrong");
endmodule
bind fld_top fld_top_asserts i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .reg_chan(reg_chan), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .coarse_mag(coarse_mag),
  .sample_data(sample_data), .ovr_in(ovr_in), .level_flag_pins(level_flag_pins));
`default_nettype wire

// ### verification/fld_gain_ctl.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// far side: gain logic latching the flag pins each sample
module fld_gain_ctl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // pins in, captured copy out
  input wire logic [7:0] level_flag_pins,
  output logic [7:0] cap_q
);
  // pins are registered at the source, so no resync stage
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      cap_q <= 8'h00;
    else
      cap_q <= level_flag_pins;
  end
endmodule
`default_nettype wire

// ### verification/tb_fld_top.sv
`timescale 1ns/1ns
`default_nettype none
// ====
// bench: random datapath against a per-channel model
module tb_fld_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_chan = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] coarse_mag = 8'h00;
  logic [19:0] sample_data = 20'h00000;
  logic [1:0] ovr_in = 2'h0;
  wire [7:0] reg_rdata;
  wire [7:0] level_flag_pins;
  wire [7:0] cap_q;
  integer errors = 0, check_count = 0, cyc = 0, ticks = 0, i, r, q;
  integer seed = 32'h7c999289;
  logic chk_on = 1'b0; // compare only after the history refilled
  logic [3:0] cd;
  logic [3:0] ctl [2]; // model control registers
  logic [3:0] hc [2][1024];
  logic ho [2][1024];
  logic [9:0] hs [2][1024];
  always #20 sys_clk = ~sys_clk;
  fld_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_chan(reg_chan),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .coarse_mag(coarse_mag), .sample_data(sample_data),
    .ovr_in(ovr_in), .level_flag_pins(level_flag_pins));
  fld_gain_ctl i_far (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .level_flag_pins(level_flag_pins), .cap_q(cap_q));
  task check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic [2:0] m3(input logic [3:0] c);
    m3 = (c > 4'h7) ? 3'h7 : c[2:0]; // code 8 folds into 7
  endfunction
  function automatic [13:0] fm(input logic [9:0] s);
    fm = {(s[9] ? 10'h000 - s : s), 4'h0}; // sign dropped
  endfunction
  // model: cut level 4, fine-low 0x800, fine-high 0, dwell 1
  function automatic [3:0] expn(input integer ch, input integer k);
    logic o, cu, fu, fl;
    o = ho[ch][k-12];
    cu = m3(hc[ch][k-2]) >= 3'h4 || m3(hc[ch][k-3]) >= 3'h4;
    fu = fm(hs[ch][k-2]) > 14'h0000;
    fl = fm(hs[ch][k-2]) < 14'h0800;
    case (ctl[ch][3:1])
      3'h0: expn = hc[ch][k-2];
      3'h1: expn = {m3(hc[ch][k-6]), o};
      3'h2: expn = {2'(m3(hc[ch][k-6]) >> 1), o, fl};
      3'h3: expn = {2'(m3(hc[ch][k-6]) >> 1), cu, fl};
      3'h4: expn = {o, cu, fu, fl};
      3'h5: expn = {o, fu, fl, cu};
      default: expn = 4'h0;
    endcase
    if (!ctl[ch][0])
      expn = 4'h0;
  endfunction
  // history of what each edge sampled
  always @(posedge sys_clk)
  begin
    hc[0][cyc] = coarse_mag[3:0];
    hc[1][cyc] = coarse_mag[7:4];
    ho[0][cyc] = ovr_in[0];
    ho[1][cyc] = ovr_in[1];
    hs[0][cyc] = sample_data[9:0];
    hs[1][cyc] = sample_data[19:10];
    cyc++;
    ticks++;
    if (ticks > 1000)
    begin
      errors++;
      end_sim();
    end
  end
  // compare settled pins, then drive fresh random inputs
  always @(negedge sys_clk)
  begin
    if (chk_on)
    begin
      check(level_flag_pins, {expn(1, cyc), expn(0, cyc)});
      check(cap_q, {expn(1, cyc - 1), expn(0, cyc - 1)});
    end
    r = $random(seed);
    q = $random(seed);
    coarse_mag <= {r[7:4] % 4'h9, r[3:0] % 4'h9};
    ovr_in <= r[9:8];
    sample_data <= q[19:0];
  end
  task wr(input logic ch, input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_chan = ch;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    if (a == 12'h104)
      ctl[ch] = d[3:0];
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task rd(input logic ch, input logic [11:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_chan = ch;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    check(reg_rdata, e);
  endtask
  initial
  begin
    ctl[0] = 4'h0;
    ctl[1] = 4'h0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    check(reg_rdata, 8'h00);
    check(level_flag_pins, 8'h00);
    rd(0, 12'h104, 8'h00);
    rd(1, 12'h105, 8'h07);
    rd(0, 12'h10a, 8'h01);
    rd(0, 12'h0ff, 8'h00);
    for (i = 0; i < 2; i++)
    begin
      wr(i[0], 12'h109, 8'h08);
      wr(i[0], 12'h105, 8'h04);
    end
    wr(0, 12'h104, 8'hf3);
    rd(0, 12'h104, 8'h03);
    // every mode enabled, then one disabled; channel 1 differs
    for (i = 0; i < 9; i++)
    begin
      cd = (i < 8) ? {i[2:0], 1'b1} : 4'h8;
      wr(0, 12'h104, {4'h0, cd});
      wr(1, 12'h104, {4'h0, cd ^ 4'h6});
      repeat (16) @(posedge sys_clk);
      chk_on = 1'b1;
      repeat (30) @(posedge sys_clk);
      chk_on = 1'b0;
    end
    end_sim();
  end
endmodule
`default_nettype wire
